/* logic/reset_strap_sampler.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Strap sampler for dual-use output pins.
module reset_strap_sampler
  import strap_pkg::*;
#(
  parameter int STRAPS = STRAP_WIDTH,
  parameter int PLLS = PLL_WIDTH
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hard_reset_in_n,
  input wire logic [STRAPS-1:0] strap_pin_in,
  input wire logic [PLLS-1:0] pll_pin_in,
  input wire logic [STRAPS-1:0] func_out,
  input wire logic [PLLS-1:0] pll_func_out,
  output logic [STRAPS-1:0] strap_pin_out,
  output logic [STRAPS-1:0] strap_pin_oe_n,
  output logic [PLLS-1:0] pll_pin_out,
  output logic [PLLS-1:0] pll_pin_oe_n,
  output logic pullup_en,
  output logic receiver_en,
  output logic [STRAPS-1:0] cfg_value,
  output logic [PLLS-1:0] pll_cfg_value,
  output logic cfg_valid
);
  strap_state_type state_q;
  strap_state_type state_d;
  logic [HOLD_CNT_WIDTH-1:0] hold_cnt_q;
  logic capture;
  logic in_reset;

  assign in_reset = !hard_reset_in_n;

  // =====================================================================
  // Sequence: reset, pull-up hold after release, then normal run.
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (!in_reset) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (in_reset) begin
          state_d = ST_RESET;
        end else if (hold_cnt_q == HOLD_CNT_WIDTH'(PULLUP_HOLD_CYCLES - 1)) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (in_reset) begin
          state_d = ST_RESET;
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  // State register; block reset returns to the reset phase.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Counts the extra pull-up cycles after release.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hold_cnt_q <= '0;
    end else if (state_q == ST_HOLD) begin
      hold_cnt_q <= hold_cnt_q + HOLD_CNT_WIDTH'(1);
    end else begin
      hold_cnt_q <= '0;
    end
  end

  // RL2 capture at release
  // Sample in the cycle the reset input is first seen released; pins still carry straps.
  assign capture = (state_q == ST_RESET) && !in_reset;

  // RL7 hold captured values
  strap_capture_reg #(
    .WIDTH(STRAPS),
    .INIT(STRAP_RESET_VALUE)
  ) u_strap_cap (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(capture),
    .din(strap_pin_in),
    .dout(cfg_value)
  );

  strap_capture_reg #(
    .WIDTH(PLLS),
    .INIT(PLL_RESET_VALUE)
  ) u_pll_cap (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(capture),
    .din(pll_pin_in),
    .dout(pll_cfg_value)
  );

  // Valid from the cycle after capture until reset is asserted again.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cfg_valid <= 1'b0;
    end else if (in_reset) begin
      cfg_valid <= 1'b0;
    end else if (capture) begin
      cfg_valid <= 1'b1;
    end
  end

  // RL4 RL5 pull-up window
  // Pull-up spans reset plus hold; it drops with the receiver so the output is clean.
  assign pullup_en = (state_q != ST_RUN);
  // RL3 receiver off
  assign receiver_en = (state_q != ST_RUN);

  // RL1 pins released
  // Pins drive only in run; during reset and hold they stay inputs.
  assign strap_pin_oe_n = (state_q == ST_RUN) ? '0 : '1;
  assign pll_pin_oe_n = (state_q == ST_RUN) ? '0 : '1;

  // RL3 normal function
  // Data outputs are registered copies of the functional values.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      strap_pin_out <= '0;
      pll_pin_out <= '0;
    end else begin
      strap_pin_out <= func_out;
      pll_pin_out <= pll_func_out;
    end
  end

  // =====================================================================
  // Checks

  // RL1 released in reset
  pins_released_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL1
    $past(in_reset) && in_reset |-> strap_pin_oe_n == '1 && pll_pin_oe_n == '1)
    else $error("pins driven during hard reset");

  // RL2 capture value
  capture_value_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL2
    capture |=> cfg_value == $past(strap_pin_in) && cfg_valid)
    else $error("strap not captured at release");

  // RL3 receiver timing
  receiver_off_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL3
    capture ##1 !in_reset [*4] |=> !receiver_en && strap_pin_oe_n == '0)
    else $error("receiver not off after hold");

  // RL4 pull-up hold
  pullup_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL4
    capture |=> pullup_en [*3])
    else $error("pull-up dropped too early");

  // RL4 pull-up with receiver
  pullup_receiver_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL4
    pullup_en == receiver_en)
    else $error("pull-up and receiver disagree");

  // RL7 values stable
  values_stable_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL7
    cfg_valid && !capture |=> $stable(cfg_value) && $stable(pll_cfg_value))
    else $error("captured value changed");

  // RL7 valid drops
  valid_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL7
    in_reset |=> !cfg_valid)
    else $error("valid held through reset");

  // RL2 pll capture
  pll_capture_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL2
    capture |=> pll_cfg_value == $past(pll_pin_in))
    else $error("pll strap not captured");

  // RL4 pull-up in reset
  pullup_in_reset_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL4
    $past(in_reset) && in_reset |-> pullup_en && receiver_en)
    else $error("pull-up off during hard reset");

  // RL1 released in hold
  hold_released_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL1
    state_q == ST_HOLD |-> strap_pin_oe_n == '1 && pll_pin_oe_n == '1)
    else $error("pins driven during pull-up hold");

  // RL3 pins driven in run
  run_drives_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL3
    state_q == ST_RUN |-> strap_pin_oe_n == '0 && pll_pin_oe_n == '0 && !receiver_en)
    else $error("pins not restored in run");

  // RL3 output copy
  pin_out_copy_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL3
    1'b1 |=> strap_pin_out == $past(func_out) && pll_pin_out == $past(pll_func_out))
    else $error("pin data not following function");

  // RL4 abort in hold
  hold_abort_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL4
    state_q == ST_HOLD && in_reset |=> state_q == ST_RESET && !cfg_valid)
    else $error("hold not aborted by hard reset");

  // RL7 frozen in reset
  reset_frozen_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL7
    in_reset |=> $stable(cfg_value) && $stable(pll_cfg_value))
    else $error("captured value changed in reset");

  // RL5 default high
  default_high_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL5
    capture && strap_pin_in == '1 |=> cfg_value == '1)
    else $error("high strap not taken as default");

  // RL7 valid in run
  valid_in_run_a: assert property (@(posedge sys_clk) disable iff (!nrst) // RL7
    state_q == ST_RUN |-> cfg_valid)
    else $error("valid lost while running");
endmodule : reset_strap_sampler
`default_nettype wire

/* logic/strap_capture_reg.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Capture register: loads once on the capture pulse, holds otherwise.
module strap_capture_reg #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // Hold value until the next capture; only reset or load changes it.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dout <= INIT;
    end else if (load) begin
      dout <= din;
    end
  end
endmodule : strap_capture_reg
`default_nettype wire

/* logic/strap_pkg.sv */
// What this block does
// RL1: While hard reset is asserted every configuration pin is released so the board can drive it.
// RL2: The level on each configuration pin is captured as hard reset deasserts; the board holds it all through reset.
// RL3: After capture the input receiver is switched off and the pin returns to its normal output role.
// RL4: The pull-up is on during hard reset and a few platform clocks after, then goes off with the receiver.
// RL5: A high sample on a pulled-up pin selects the default, so the board pulls low only for non-default settings.
// RL6: The board drives the PLL ratio pins itself during reset because they carry no pull-up.
// RL7: Captured values stay unchanged until hard reset is asserted again, whatever the pins do later.
`default_nettype none
package strap_pkg;
  // =====================================================================
  // Sizes and timing
  localparam int STRAP_WIDTH = 24;
  localparam int PLL_WIDTH = 8;
  // Platform clocks of extra pull-up time after reset release.
  localparam int PULLUP_HOLD_CYCLES = 4;
  localparam int HOLD_CNT_WIDTH = 3;
  // Captured value before any capture: straps all defaults (high), PLL ratio all zero.
  localparam logic [STRAP_WIDTH-1:0] STRAP_RESET_VALUE = 24'hFFFFFF;
  localparam logic [PLL_WIDTH-1:0] PLL_RESET_VALUE = 8'h00;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b10
  } strap_state_type;
endpackage : strap_pkg
`default_nettype wire

/* test/strap_board_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ======================================================================
// Board side: pull-down resistors on straps and driven PLL ratio pins.
module strap_board_model
  import strap_pkg::*;
(
  input wire logic sys_clk,
  input wire logic pullup_en,
  input wire logic [STRAP_WIDTH-1:0] pull_low,
  input wire logic [PLL_WIDTH-1:0] pll_level,
  output logic [STRAP_WIDTH-1:0] strap_pin_in,
  output logic [PLL_WIDTH-1:0] pll_pin_in
);
  logic churn = 1'b0;
  // Released lines flip every cycle so a stale level can never pass for a capture.
  always @(posedge sys_clk) churn <= ~churn;
  assign strap_pin_in = pullup_en ? ~pull_low : {STRAP_WIDTH{churn}};
  assign pll_pin_in = pullup_en ? pll_level : {PLL_WIDTH{churn}};
endmodule : strap_board_model
`default_nettype wire

/* test/test_reset_strap_sampler.sv */
`timescale 1ns/10ps
`default_nettype none
// ======================================================================
// Bench for the strap sampler.
module test_reset_strap_sampler;
  import strap_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic hrst_n = 1'b0;
  logic [23:0] low = 24'h0;
  logic [7:0] pll = 8'h0;
  logic [23:0] fo = 24'h5A5A5A;
  logic [7:0] pfo = 8'hC3;
  logic [23:0] spi, so, soe, cfg;
  logic [7:0] ppi, po, poe, pcfg;
  logic pu, rx, vld;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  strap_board_model board (.sys_clk(sys_clk), .pullup_en(pu), .pull_low(low),
    .pll_level(pll), .strap_pin_in(spi), .pll_pin_in(ppi));
  reset_strap_sampler uut (.sys_clk(sys_clk), .nrst(nrst), .hard_reset_in_n(hrst_n),
    .strap_pin_in(spi), .pll_pin_in(ppi), .func_out(fo), .pll_func_out(pfo),
    .strap_pin_out(so), .strap_pin_oe_n(soe), .pll_pin_out(po), .pll_pin_oe_n(poe),
    .pullup_en(pu), .receiver_en(rx), .cfg_value(cfg), .pll_cfg_value(pcfg),
    .cfg_valid(vld));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  // A hang counts as a mismatch.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  // Hold hard reset, release, then follow capture, hold window and run.
  task automatic capture(input logic [23:0] m, input logic [7:0] p);
    hrst_n = 1'b0;
    low = m;
    pll = p;
    fo = m ^ 24'h5A5A5A;
    pfo = p ^ 8'hC3;
    step(3);
    chk("oe_n", 32'hFFFFFFFF, {soe, poe});
    hrst_n = 1'b1;
    step(2);
    chk("cfg", {pll, ~m}, {pcfg, cfg});
    chk("valid", 32'h1, {31'h0, vld});
    step(2);
    chk("hold", 32'h3, {30'h0, pu, rx});
    chk("oe_hold", 32'hFFFFFFFF, {soe, poe});
    step(1);
    chk("run", 32'h0, {30'h0, pu, rx});
    chk("oe_run", 32'h0, {soe, poe});
    chk("pin_out", {pfo, fo}, {po, so});
    step(6);
    chk("frozen", {pll, ~m}, {pcfg, cfg});
    chk("valid_run", 32'h1, {31'h0, vld});
  endtask : capture
  // Hard reset again inside the hold window.
  task automatic abort_hold();
    hrst_n = 1'b0;
    step(2);
    hrst_n = 1'b1;
    step(2);
    hrst_n = 1'b0;
    step(1);
    chk("abort", 32'h3, {29'h0, vld, pu, rx});
    step(4);
    chk("abort_oe", 32'hFFFFFFFF, {soe, poe});
    chk("abort_pu", 32'h3, {30'h0, pu, rx});
    chk("abort_cfg", {pll, ~low}, {pcfg, cfg});
  endtask : abort_hold
  task automatic wrap_up();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    step(3);
    nrst = 1'b1;
    capture(24'h000000, 8'h00);
    capture(24'hFFFFFF, 8'hFF);
    abort_hold();
    capture(24'hA5C30F, 8'h96);
    wrap_up();
  end
endmodule : test_reset_strap_sampler
`default_nettype wire
